/* File: src/sfh_pkg.sv */
// sfh_pkg: opcodes, widths and reset values for the serial flash command front end
package sfh_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0B;
  localparam logic [7:0] OP_PARAM_RD   = 8'h5A;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_QIO_FIXED  = 8'hE7;
  localparam logic [7:0] OP_QIO_CFG    = 8'hEB;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_SET_WEL    = 8'h06;
  localparam logic [7:0] OP_CLR_WEL    = 8'h04;
  localparam logic [7:0] OP_STAT_RD    = 8'h05;
  localparam logic [7:0] OP_CFG_RD     = 8'h15;
  localparam logic [7:0] OP_STAT_WR    = 8'h01;
  localparam logic [7:0] OP_QUAD_PP    = 8'h38;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLK   = 8'h52;
  localparam logic [7:0] OP_BLK_ERASE  = 8'hD8;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_CONT_PROG  = 8'hAD;
  localparam logic [7:0] OP_CHIP_ER_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ER_B  = 8'hC7;
  localparam logic [7:0] OP_DPD_ENTER  = 8'hB9;
  localparam logic [7:0] OP_DPD_EXIT   = 8'hAB;
  localparam logic [7:0] OP_IDENT_RD   = 8'h9F;
  localparam logic [7:0] OP_MPC_RD     = 8'h90;
  localparam logic [7:0] OP_MPC_RD2    = 8'hEF;
  localparam logic [7:0] OP_MPC_RD4    = 8'hDF;
  localparam logic [7:0] OP_OTP_ENTER  = 8'hB1;

  // ****************************************
  // field positions, counts, reset values
  // ****************************************
  localparam int         CFG_DC_BIT    = 7;
  localparam logic [3:0] DUMMY_FIXED   = 4'h4;
  localparam logic [3:0] DUMMY_DC0     = 4'h6;
  localparam logic [3:0] DUMMY_DC1     = 4'h8;
  localparam logic [3:0] DUMMY_BYTE    = 4'h8;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [3:0] CMD_RST       = 4'h0;

  // ****************************************
  // command classes for opcode decoding
  // ****************************************
  typedef enum logic [3:0] {
    SFH_CMD_NONE  = 4'h0,
    SFH_CMD_READ  = 4'h1,
    SFH_CMD_ADDR  = 4'h2,
    SFH_CMD_VALUE = 4'h3,
    SFH_CMD_BARE  = 4'h4,
    SFH_CMD_IDOUT = 4'h5,
    SFH_CMD_BAD   = 4'h6
  } sfh_class_e;

endpackage

/* File: src/sfh_cmd_fifo.sv */
// sfh_cmd_fifo: two-entry valid/ready buffer for decoded command words
`timescale 1ns/10ps
module sfh_cmd_fifo
  import sfh_pkg::*;
#(
  parameter int W = 40,
  parameter int D = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          wr, rd;

  always_comb begin
    wr      = in_valid && in_ready;
    rd      = out_valid && out_ready;
    wp_nxt  = wr ? ((wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt  = rd ? ((rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
  end

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage carries no reset; only written entries are ever read
  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

/* File: src/sfh_front_end.sv */
// sfh_front_end: serial flash command decoder with pause (hold) handling
// Summary of operation
// [R1] pause only with select low; starts on pause-pin fall once clock is low
// [R2] pause ends on pause-pin rise once the serial clock is low
// [R3] pause stops the serial link only; internal write/program/erase carries on
// [R4] while paused: output high impedance, input and clock ignored
// [R5] select rising during pause resets interface logic, drops the command
// [R6] master resumes with pause pin high and select low
// [R7] pause has no effect in quad I/O mode
// [R8] read opcodes take three address bytes; all but 03h add a dummy byte
// [R9] quad output read 6Bh: three address bytes, dummy, data over four lines
// [R10] configurable quad I/O read dummy count follows configuration bit 7
// [R11] latch set/clear, status/config reads and write, quad program, sector erase
// [R12] block erases, programs take addresses; chip erase, power-down enter/exit
// [R13] identity reads, code reads after don't-care bytes, OTP region enter
// [R14] unknown opcode: standby, output off, ignore until next select fall
// [R15] input sampled on clock rise, output changed on fall; modes 0 and 3
// [R16] write/erase/program/mode commands need select rise on byte boundary
// [R17] bytes shifted most significant bit first, high address byte first
`timescale 1ns/10ps
module sfh_front_end
  import sfh_pkg::*;
(
  // system side
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // serial link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        hold_n,
  input  wire logic        si,
  output logic             so_o,
  output logic             so_oe,
  // device state
  input  wire logic        quad_mode,
  input  wire logic        cfg_dc,
  input  wire logic        busy,
  input  wire logic [7:0]  resp_byte,
  // decoded command stream
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic [7:0]       cmd_opcode,
  output logic [23:0]      cmd_addr,
  output logic [3:0]       cmd_dummy,
  output logic             cmd_ok,
  // status
  output logic             write_enable_latch,
  output logic             paused,
  output logic             standby
);

  // ****************************************
  // link-side logic on the serial clock
  // ****************************************
  typedef enum logic [4:0] {
    LK_OP   = 5'b00001,
    LK_ADDR = 5'b00010,
    LK_DUM  = 5'b00100,
    LK_DATA = 5'b01000,
    LK_IGN  = 5'b10000
  } sfh_link_e;

  function automatic sfh_class_e classify(input logic [7:0] op);
    case (op)
      OP_READ, OP_FAST_READ, OP_PARAM_RD, OP_DUAL_IO, OP_DUAL_OUT,
      OP_QIO_FIXED, OP_QIO_CFG, OP_QUAD_OUT:                classify = SFH_CMD_READ;
      OP_QUAD_PP, OP_SECT_ERASE, OP_HALF_BLK, OP_BLK_ERASE,
      OP_PAGE_PROG, OP_CONT_PROG:                           classify = SFH_CMD_ADDR;
      OP_STAT_WR:                                           classify = SFH_CMD_VALUE;
      OP_SET_WEL, OP_CLR_WEL, OP_CHIP_ER_A, OP_CHIP_ER_B,
      OP_DPD_ENTER, OP_OTP_ENTER:                           classify = SFH_CMD_BARE;
      OP_STAT_RD, OP_CFG_RD, OP_IDENT_RD, OP_DPD_EXIT,
      OP_MPC_RD, OP_MPC_RD2, OP_MPC_RD4:                    classify = SFH_CMD_IDOUT;
      default:                                              classify = SFH_CMD_BAD;
    endcase
  endfunction

  // hold gate: pause pin sampled only while sclk low; a high clock defers it
  // select is kept out of the latch so a select rise cannot race the capture
  logic hold_raw;        // [R1] [R2]
  always_latch begin
    if (!sclk) begin
      hold_raw = !hold_n && !quad_mode; // [R1] [R2] [R7]
    end
  end
  logic hold_act;
  assign hold_act = hold_raw && !cs_n; // [R1]
  // [R4] gated clock: no rising edge reaches the shifter while paused
  logic gclk;
  assign gclk = sclk && !hold_act;
  // [R5] select high clears the interface whether paused or not
  logic lrst_n;
  assign lrst_n = !cs_n;

  sfh_link_e  lst_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic [1:0] byt_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;

  always_ff @(posedge gclk or negedge lrst_n) begin
    if (!lrst_n) begin
      lst_r  <= LK_OP;
      sh_r   <= '0;
      bit_r  <= '0;
      byt_r  <= '0;
      op_r   <= '0;
      addr_r <= '0;
    end else begin
      sh_r  <= {sh_r[6:0], si};                        // [R15] [R17]
      bit_r <= bit_r + 3'h1;
      if (bit_r == BYTE_LAST_BIT) begin
        case (lst_r)
          LK_OP: begin
            op_r  <= {sh_r[6:0], si};
            byt_r <= '0;
            case (classify({sh_r[6:0], si}))
              SFH_CMD_READ, SFH_CMD_ADDR,
              SFH_CMD_VALUE: lst_r <= LK_ADDR;         // [R8] [R11] [R12]
              SFH_CMD_IDOUT: begin
                // register and identity reads answer at once; code reads take 3 bytes
                if ({sh_r[6:0], si} == OP_STAT_RD || {sh_r[6:0], si} == OP_CFG_RD ||
                    {sh_r[6:0], si} == OP_IDENT_RD) begin
                  lst_r <= LK_DATA;                    // [R11] [R13]
                end else begin
                  lst_r <= LK_ADDR;                    // [R13]
                end
              end
              SFH_CMD_BARE:  lst_r <= LK_DATA;
              default:       lst_r <= LK_IGN;          // [R14]
            endcase
          end
          LK_ADDR: begin
            addr_r <= {addr_r[15:0], sh_r[6:0], si};   // [R17]
            byt_r  <= byt_r + 2'h1;
            if (byt_r == 2'h2 || (classify(op_r) == SFH_CMD_VALUE && byt_r == 2'h1)) begin
              lst_r <= (classify(op_r) == SFH_CMD_READ && op_r != OP_READ)
                       ? LK_DUM : LK_DATA;             // [R8] [R9]
            end
          end
          LK_DUM:  lst_r <= LK_DATA;
          LK_DATA: lst_r <= LK_DATA;
          default: lst_r <= LK_IGN;
        endcase
      end
    end
  end

  // byte-boundary and payload-complete flag, sampled into sys domain on cs rise
  logic lk_complete;
  assign lk_complete = (bit_r == 3'h0) && (lst_r == LK_DATA); // [R16]
  logic lk_data;
  assign lk_data = (lst_r == LK_DATA);

  // link state is cleared by select high; snapshot it on that same edge
  logic [7:0]  cap_op_r;
  logic [23:0] cap_addr_r;
  logic        cap_done_r, cap_drop_r;
  always_ff @(posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      cap_op_r   <= '0;
      cap_addr_r <= '0;
      cap_done_r <= 1'b0;
      cap_drop_r <= 1'b0;
    end else begin
      cap_op_r   <= op_r;
      cap_addr_r <= addr_r;
      cap_done_r <= lk_complete; // [R16]
      cap_drop_r <= hold_raw;    // [R5]
    end
  end

  // [R15] output shifts on falling edge of the gated clock
  logic [7:0] osh_r;
  always_ff @(negedge gclk or negedge lrst_n) begin
    if (!lrst_n) begin
      osh_r <= '0;
    end else begin
      osh_r <= (bit_r == 3'h0) ? resp_byte : {osh_r[6:0], 1'b0};
    end
  end

  // ****************************************
  // synchronisers into the system clock
  // ****************************************
  logic [2:0] cs_s1_r, cs_s2_r;
  logic [2:0] cs_meta;
  assign cs_meta = {cs_n, hold_act, lk_data};
  logic       cs_d_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_s1_r <= 3'h4;
      cs_s2_r <= 3'h4;
      cs_d_r  <= 1'b1;
    end else begin
      cs_s1_r <= cs_meta;
      cs_s2_r <= cs_s1_r;
      cs_d_r  <= cs_s2_r[2];
    end
  end
  logic cs_rise, cs_fall;
  assign cs_rise = cs_s2_r[2] && !cs_d_r;
  assign cs_fall = !cs_s2_r[2] && cs_d_r;

  // ****************************************
  // system-side command capture
  // ****************************************
  // snapshot stays stable until the next select rise, well after its use here
  logic        wel_r, wel_nxt, stb_r, stb_nxt, pause_r;
  logic        push_v, push_rdy;
  sfh_class_e  cls;
  logic        ok;

  always_comb begin
    cls      = classify(cap_op_r);
    ok       = (cls == SFH_CMD_READ) || (cls == SFH_CMD_IDOUT) || cap_done_r; // [R16]
    // a pause abandoned by select high is dropped, never queued
    push_v   = cs_rise && cls != SFH_CMD_BAD && !cap_drop_r; // [R5]
    wel_nxt  = wel_r;
    stb_nxt  = stb_r;
    if (cs_rise && ok && !cap_drop_r) begin
      if (cap_op_r == OP_SET_WEL) wel_nxt = 1'b1;      // [R11]
      if (cap_op_r == OP_CLR_WEL) wel_nxt = 1'b0;      // [R11]
      if (cls == SFH_CMD_ADDR || cap_op_r == OP_STAT_WR ||
          cap_op_r == OP_CHIP_ER_A || cap_op_r == OP_CHIP_ER_B) wel_nxt = 1'b0;
    end
    if (cs_rise && cls == SFH_CMD_BAD) stb_nxt = 1'b1; // [R14]
    if (cs_fall) stb_nxt = 1'b0;                       // [R14]
  end

  logic [3:0] dum_cnt;
  always_comb begin
    case (cap_op_r)
      OP_READ:      dum_cnt = CMD_RST;
      OP_QIO_FIXED: dum_cnt = DUMMY_FIXED;
      OP_QIO_CFG:   dum_cnt = cfg_dc ? DUMMY_DC1 : DUMMY_DC0; // [R10]
      default:      dum_cnt = (cls == SFH_CMD_READ) ? DUMMY_BYTE : CMD_RST;
    endcase
  end

  logic [39:0] fifo_out;
  logic        fifo_v;
  // pop exactly when the output register takes the word, so none is replayed
  sfh_cmd_fifo #(.W(40), .D(2)) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   ({cap_op_r, cap_addr_r, dum_cnt, ok, 3'h0}),
    .out_valid (fifo_v),
    .out_ready (!cmd_valid),
    .out_data  (fifo_out)
  );

  // registered outputs; busy work inside the device is untouched by a pause [R3]
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wel_r     <= 1'b0;
      stb_r     <= 1'b0;
      pause_r   <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_opcode <= '0;
      cmd_addr  <= '0;
      cmd_dummy <= '0;
      cmd_ok    <= 1'b0;
      so_o      <= 1'b0;
      so_oe     <= 1'b0;
    end else begin
      wel_r     <= wel_nxt;
      stb_r     <= stb_nxt;
      pause_r   <= cs_s2_r[1];
      if (cmd_valid && cmd_ready) cmd_valid <= 1'b0;
      else if (fifo_v && !cmd_valid) begin
        cmd_valid  <= 1'b1;
        cmd_opcode <= fifo_out[39:32];
        cmd_addr   <= fifo_out[31:8];
        cmd_dummy  <= fifo_out[7:4];
        cmd_ok     <= fifo_out[3];
      end
      so_o  <= osh_r[7];
      so_oe <= !cs_s2_r[2] && !cs_s2_r[1] && !stb_r && cs_s2_r[0]; // [R4] [R14]
    end
  end

  assign write_enable_latch = wel_r;
  assign paused  = pause_r;
  assign standby = stb_r;

  // ****************************************
  // checks
  // ****************************************
  a_pause_so_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_s2_r[1] |=> !so_oe) else $error("output driven while paused"); // [R4]
  a_bad_standby: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cs_rise && cls == SFH_CMD_BAD) |=> standby) else $error("no standby"); // [R14]
  a_standby_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    standby |=> !so_oe) else $error("output driven in standby"); // [R14]
  a_set_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cs_rise && ok && !cap_drop_r && cap_op_r == OP_SET_WEL) |=> write_enable_latch)
    else $error("latch not set"); // [R11]
  a_clr_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cs_rise && ok && !cap_drop_r && cap_op_r == OP_CLR_WEL) |=> !write_enable_latch)
    else $error("latch not cleared"); // [R11]
  a_cfg_dummy: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cap_op_r == OP_QIO_CFG) |-> dum_cnt == (cfg_dc ? DUMMY_DC1 : DUMMY_DC0))
    else $error("dummy count wrong"); // [R10]
  a_abandon_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cap_drop_r && cs_rise) |-> !push_v) else $error("abandoned command queued"); // [R5]
  a_boundary_ok: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cs_rise && cls == SFH_CMD_ADDR && !cap_done_r) |-> !ok)
    else $error("off-boundary write accepted"); // [R16]

endmodule

/* File: bench/sfh_spi_master.sv */
// sfh_spi_master: serial master model for the flash link pins
`timescale 1ns/10ps
module sfh_spi_master (
  // link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      hold_n,
  output logic      si,
  // flash output
  input  wire logic so_o
);
  logic [7:0] rx;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    si = 1'b0;
  end

  // ****************************************
  // bit and byte transfers, mode 0, 15 ns clock
  // ****************************************
  // data set while clock low, flash samples on rise
  task automatic bit_io(input logic v);
    si = v;
    #7.5 sclk = 1'b1;
    rx = {rx[6:0], so_o};
    #7.5 sclk = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i]);
    end
  endtask

  task automatic open_frame();
    cs_n = 1'b0;
    #7.5;
  endtask

  // clock stands low between frames; released data line shows inverted level
  task automatic close_frame();
    #7.5 cs_n = 1'b1;
    si = ~si;
    #40;
  endtask

  // pause pin moved only while the clock is low
  task automatic set_hold(input logic v);
    hold_n = v;
    #20;
  endtask
endmodule

/* File: bench/sfh_front_end_bench.sv */
// sfh_front_end_bench: self-checking bench for the command front end
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sfh_front_end_bench
  import sfh_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        cmd_ready = 1'b0;
  logic        quad_mode = 1'b0;
  logic        cfg_dc = 1'b0;
  logic        busy = 1'b0;
  logic [7:0]  resp_byte = 8'hC3;
  wire         sclk, cs_n, hold_n, si, so_o, so_oe, cmd_valid, cmd_ok;
  wire         write_enable_latch, paused, standby;
  wire  [7:0]  cmd_opcode;
  wire  [23:0] cmd_addr;
  wire  [3:0]  cmd_dummy;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  aops [17] = '{OP_READ, OP_FAST_READ, OP_PARAM_RD, OP_DUAL_IO, OP_DUAL_OUT,
    OP_QIO_FIXED, OP_QIO_CFG, OP_QUAD_OUT, OP_SECT_ERASE, OP_HALF_BLK, OP_BLK_ERASE,
    OP_PAGE_PROG, OP_CONT_PROG, OP_QUAD_PP, OP_MPC_RD, OP_MPC_RD2, OP_MPC_RD4};
  logic [7:0]  bops [10] = '{OP_SET_WEL, OP_CLR_WEL, OP_STAT_RD, OP_CFG_RD, OP_CHIP_ER_A,
    OP_CHIP_ER_B, OP_DPD_ENTER, OP_DPD_EXIT, OP_IDENT_RD, OP_OTP_ENTER};

  always #2 clk_sys = ~clk_sys;

  sfh_spi_master master (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .si(si), .so_o(so_o));

  sfh_front_end uut (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .hold_n(hold_n), .si(si), .so_o(so_o), .so_oe(so_oe), .quad_mode(quad_mode),
    .cfg_dc(cfg_dc), .busy(busy), .resp_byte(resp_byte), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
    .cmd_dummy(cmd_dummy), .cmd_ok(cmd_ok), .write_enable_latch(write_enable_latch),
    .paused(paused), .standby(standby));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic send(input logic [7:0] op, input logic [23:0] ad, input int na,
                      input int nd);
    master.open_frame();
    master.byte_io(op);
    for (int i = na - 1; i >= 0; i--) begin
      master.byte_io(ad[i*8 +: 8]);
    end
    repeat (nd) master.byte_io(8'h00);
    master.close_frame();
  endtask

  // what[0] checks the address, what[1] the dummy count
  task automatic get_cmd(input logic [7:0] op, input logic [23:0] ad, input logic [3:0] dm,
                         input logic ok, input logic [1:0] what);
    int n;
    n = 0;
    tick(1);
    while (cmd_valid !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    `CHK("valid", 1'b1, cmd_valid)
    `CHK("opcode", op, cmd_opcode)
    `CHK("ok", ok, cmd_ok)
    if (what[0]) `CHK("addr", ad, cmd_addr)
    if (what[1]) `CHK("dummy", dm, cmd_dummy)
    cmd_ready = 1'b1;
    tick(1);
    cmd_ready = 1'b0;
  endtask

  task automatic no_cmd();
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      tick(1);
      if (cmd_valid === 1'b1) seen = 1'b1;
    end
    `CHK("no cmd", 1'b0, seen)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, about five times the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [23:0] ad;
    logic [3:0]  dm;
    int          j;
    tick(8);
    rstn = 1'b1;
    tick(4);
    `CHK("reset", 5'h00, {cmd_valid, paused, standby, write_enable_latch, so_oe})
    for (int i = 0; i < 10; i++) begin
      send(bops[i], 24'h0, 0, 0);
      get_cmd(bops[i], 24'h0, 4'h0, 1'b1, 2'b00);
      if (i < 2) `CHK("latch", (i == 0), write_enable_latch)
    end
    for (int i = 0; i < 18; i++) begin
      // last pass repeats the configurable quad read with the select bit set
      j = (i == 17) ? 6 : i;
      if (i == 17) begin
        tick(1);
        cfg_dc = 1'b1;
      end
      ad = (i == 0) ? 24'hFFFFFF : {i[7:0], 16'hA50F};
      dm = (j == 0) ? 4'h0 : (j == 5) ? DUMMY_FIXED : (i == 6) ? DUMMY_DC0 :
           (i == 17) ? DUMMY_DC1 : DUMMY_BYTE;
      send(aops[j], ad, 3, (j > 0 && j < 8) ? 1 : 0);
      get_cmd(aops[j], ad, dm, 1'b1, {j < 8, j < 14});
    end
    send(OP_STAT_WR, 24'h005AC3, 2, 0);
    get_cmd(OP_STAT_WR, 24'h005AC3, 4'h0, 1'b1, 2'b00);
    `CHK("value", 16'h5AC3, cmd_addr[15:0])
    master.open_frame();
    master.byte_io(OP_STAT_RD);
    master.byte_io(8'h00);
    `CHK("so drive", 1'b1, so_oe)
    master.close_frame();
    `CHK("so data", 8'hC3, master.rx)
    get_cmd(OP_STAT_RD, 24'h0, 4'h0, 1'b1, 2'b00);
    send(8'h77, 24'h0, 0, 0);
    no_cmd();
    `CHK("standby", 1'b1, standby)
    `CHK("so off", 1'b0, so_oe)
    send(OP_SET_WEL, 24'h0, 0, 0);
    get_cmd(OP_SET_WEL, 24'h0, 4'h0, 1'b1, 2'b00);
    `CHK("awake", 1'b0, standby)
    // two commands queue while the consumer stalls
    send(OP_CLR_WEL, 24'h0, 0, 0);
    send(OP_CFG_RD, 24'h0, 0, 0);
    get_cmd(OP_CLR_WEL, 24'h0, 4'h0, 1'b1, 2'b00);
    get_cmd(OP_CFG_RD, 24'h0, 4'h0, 1'b1, 2'b00);
    master.open_frame();
    master.byte_io(OP_SET_WEL);
    repeat (3) master.bit_io(1'b1);
    master.close_frame();
    get_cmd(OP_SET_WEL, 24'h0, 4'h0, 1'b0, 2'b00);
    `CHK("no latch", 1'b0, write_enable_latch)
    master.open_frame();
    master.byte_io(OP_SECT_ERASE);
    master.byte_io(8'h12);
    busy = 1'b1;
    master.set_hold(1'b0);
    tick(6);
    `CHK("paused", 1'b1, paused)
    `CHK("so hiz", 1'b0, so_oe)
    master.byte_io(8'hFF);
    master.set_hold(1'b1);
    tick(6);
    `CHK("resumed", 1'b0, paused)
    master.byte_io(8'h34);
    master.byte_io(8'h56);
    master.close_frame();
    get_cmd(OP_SECT_ERASE, 24'h123456, 4'h0, 1'b1, 2'b01);
    busy = 1'b0;
    master.open_frame();
    master.byte_io(OP_SET_WEL);
    master.set_hold(1'b0);
    master.close_frame();
    master.set_hold(1'b1);
    no_cmd();
    `CHK("dropped", 1'b0, write_enable_latch)
    tick(1);
    quad_mode = 1'b1;
    master.open_frame();
    master.set_hold(1'b0);
    tick(6);
    `CHK("quad no pause", 1'b0, paused)
    master.byte_io(OP_SET_WEL);
    master.set_hold(1'b1);
    master.close_frame();
    get_cmd(OP_SET_WEL, 24'h0, 4'h0, 1'b1, 2'b00);
    quad_mode = 1'b0;
    conclude();
  end
endmodule
